/* File: core/pss_pkg.sv */
// Constants and types shared by the sleep-stage power sequencer
// Summary of operation
// - The stage-two sleep config dwell field (bits 20:16, reset 16) selects a stay of 2^n clock cycles.
// - The sequencer stays exactly the programmed dwell in sleep stage two and applies its settings throughout.
// - Config bit 14 set gates the processor tile clock during sleep stage two; it resets to 0.
// - Config bit 9 picks analog buck modulation in sleep stage two, 0 PWM and 1 PFM, reset 0.
// - Config bit 8 picks core buck modulation in sleep stage two, 0 PWM and 1 PFM, reset 0.
// - Config bit 5 enables the IO supply output in sleep stage two, reset 0.
// - Config bit 4 enables the PLL linear regulator in sleep stage two, reset 0.
// - Config bit 0 enables the core buck converter in sleep stage two, reset 0.
// - Config bit 1 is read-only 1, so the analog buck stays on in sleep stage two.
// - Status bits 18:16 give the current state, 0 reset through 7 sleep stage two.
// - Status bits 29, 28, 25, 24 show IO, PLL, analog and core enables of the previous state, reset 0, 0, 1, 0.
// - The status register is read-only and bits 14, 9, 8, 5, 4, 1, 0 mirror the settings now applied.
// - Wake stage two leaves after its minimum dwell only once the core buck and PLL regulator, where enabled, report good.
package pss_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] SLP2_CFG_OFS = 8'h20;
  localparam logic [7:0] SEQ_STAT_OFS = 8'h24;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int DWELL_LSB     = 16;
  localparam int DWELL_MSB     = 20;
  localparam int CLK_GATE_BIT  = 14;
  localparam int ANA_PFM_BIT   = 9;
  localparam int CORE_PFM_BIT  = 8;
  localparam int IO_EN_BIT     = 5;
  localparam int PLL_EN_BIT    = 4;
  localparam int ANA_EN_BIT    = 1;
  localparam int CORE_EN_BIT   = 0;
  localparam int STATE_LSB     = 16;
  localparam int STATE_MSB     = 18;
  localparam int PREV_IO_BIT   = 29;
  localparam int PREV_PLL_BIT  = 28;
  localparam int PREV_ANA_BIT  = 25;
  localparam int PREV_CORE_BIT = 24;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [4:0] DWELL_RST     = 5'h10;
  localparam logic       CLK_GATE_RST  = 1'h0;
  localparam logic       ANA_PFM_RST   = 1'h0;
  localparam logic       CORE_PFM_RST  = 1'h0;
  localparam logic       IO_EN_RST     = 1'h0;
  localparam logic       PLL_EN_RST    = 1'h0;
  localparam logic       ANA_EN_FIXED  = 1'h1;
  localparam logic       CORE_EN_RST   = 1'h0;
  localparam logic       PREV_IO_RST   = 1'h0;
  localparam logic       PREV_PLL_RST  = 1'h0;
  localparam logic       PREV_ANA_RST  = 1'h1;
  localparam logic       PREV_CORE_RST = 1'h0;
  localparam logic [31:0] RESET_STATE_CFG = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Sequencer states, in status encoding order
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    st_reset,
    st_asleep,
    st_waking_one,
    st_wake_stage_two,
    st_awake_wait,
    st_awake,
    st_sleep_entry_stage_one,
    st_sleep_entry_stage_two
  } pss_state_t;

endpackage

/* File: core/pss_dwell_timer.sv */
// Dwell timer: counts a power-of-two stay from the moment of loading
`timescale 1ns/1ns
module pss_dwell_timer
  import pss_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter int LOG_W = 5
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Control
  input  wire logic             load,
  input  wire logic [LOG_W-1:0] log2_len,
  // Status
  output logic                  expired
);

  logic [CNT_W-1:0] remain;
  logic [CNT_W-1:0] next_remain;

  // Length minus one, so a stay of 2^n cycles ends on the last one
  always_comb begin
    next_remain = (CNT_W'(1) << log2_len) - CNT_W'(1);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      remain <= '0;
    end else if (load) begin
      remain <= next_remain;
    end else if (remain != '0) begin
      remain <= remain - CNT_W'(1);
    end
  end

  // Count only: gating with load would close a loop through the next-state logic
  assign expired = (remain == '0);

endmodule

/* File: core/pss_sequencer.sv */
// Power sequencer with sleep stage two configuration and status registers
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 32
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // Per-state settings held elsewhere
  input  wire logic [31:0]       cfg_asleep,
  input  wire logic [31:0]       cfg_waking_one,
  input  wire logic [31:0]       cfg_wake_stage_two,
  input  wire logic [31:0]       cfg_awake,
  input  wire logic [31:0]       cfg_sleep_entry_stage_one,
  // Requests from the power controller
  input  wire logic              sleep_req,
  input  wire logic              wake_req,
  // Supply good pins
  input  wire logic              core_good_pin,
  input  wire logic              pll_good_pin,
  // Supply and clock controls
  output logic                   core_buck_converter_en,
  output logic                   analog_buck_converter_en,
  output logic                   pll_linear_regulator_en,
  output logic                   io_supply_output_en,
  output logic                   core_buck_converter_pfm,
  output logic                   analog_buck_converter_pfm,
  output logic                   tile_clk_gate,
  output logic [2:0]             seq_state
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  pss_state_t state;
  pss_state_t next_state;

  logic [4:0]  slp2_dwell;
  logic        slp2_clk_gate;
  logic        slp2_ana_pfm;
  logic        slp2_core_pfm;
  logic        slp2_io_en;
  logic        slp2_pll_en;
  logic        slp2_core_en;
  logic [31:0] slp2_word;

  logic        applied_clk_gate;
  logic        applied_ana_pfm;
  logic        applied_core_pfm;
  logic        applied_io_en;
  logic        applied_pll_en;
  logic        applied_ana_en;
  logic        applied_core_en;

  logic        prev_io_en;
  logic        prev_pll_en;
  logic        prev_ana_en;
  logic        prev_core_en;

  logic [31:0] next_cfg;
  logic [31:0] stat_word;
  logic        state_change;
  logic        dwell_done;
  logic        supplies_good;
  logic        wr_slp2;

  logic        core_good_meta;
  logic        core_good;
  logic        pll_good_meta;
  logic        pll_good;

  // ---------------------------------------------------------------
  // Supply good synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      core_good_meta <= 1'h0;
      core_good      <= 1'h0;
    end else begin
      core_good_meta <= core_good_pin;
      core_good      <= core_good_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pll_good_meta <= 1'h0;
      pll_good      <= 1'h0;
    end else begin
      pll_good_meta <= pll_good_pin;
      pll_good      <= pll_good_meta;
    end
  end

  // A supply that is switched off has no good signal to wait for
  assign supplies_good = (!applied_core_en || core_good)
                       && (!applied_pll_en || pll_good);

  // ---------------------------------------------------------------
  // Sleep stage two configuration register
  // ---------------------------------------------------------------
  assign wr_slp2 = reg_wr && (reg_addr == ADDR_W'(SLP2_CFG_OFS));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slp2_dwell <= DWELL_RST;
    end else if (wr_slp2) begin
      slp2_dwell <= reg_wdata[DWELL_MSB:DWELL_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slp2_clk_gate <= CLK_GATE_RST;
      slp2_ana_pfm  <= ANA_PFM_RST;
      slp2_core_pfm <= CORE_PFM_RST;
    end else if (wr_slp2) begin
      slp2_clk_gate <= reg_wdata[CLK_GATE_BIT];
      slp2_ana_pfm  <= reg_wdata[ANA_PFM_BIT];
      slp2_core_pfm <= reg_wdata[CORE_PFM_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slp2_io_en   <= IO_EN_RST;
      slp2_pll_en  <= PLL_EN_RST;
      slp2_core_en <= CORE_EN_RST;
    end else if (wr_slp2) begin
      slp2_io_en   <= reg_wdata[IO_EN_BIT];
      slp2_pll_en  <= reg_wdata[PLL_EN_BIT];
      slp2_core_en <= reg_wdata[CORE_EN_BIT];
    end
  end

  // Reserved bits stay zero, analog enable is hardwired on
  always_comb begin
    slp2_word                       = '0;
    slp2_word[DWELL_MSB:DWELL_LSB]  = slp2_dwell;
    slp2_word[CLK_GATE_BIT]         = slp2_clk_gate;
    slp2_word[ANA_PFM_BIT]          = slp2_ana_pfm;
    slp2_word[CORE_PFM_BIT]         = slp2_core_pfm;
    slp2_word[IO_EN_BIT]            = slp2_io_en;
    slp2_word[PLL_EN_BIT]           = slp2_pll_en;
    slp2_word[ANA_EN_BIT]           = ANA_EN_FIXED;
    slp2_word[CORE_EN_BIT]          = slp2_core_en;
  end

  // ---------------------------------------------------------------
  // Settings of the state about to be entered
  // ---------------------------------------------------------------
  always_comb begin
    unique case (next_state)
      st_reset:                 next_cfg = RESET_STATE_CFG;
      st_asleep:                next_cfg = cfg_asleep;
      st_waking_one:            next_cfg = cfg_waking_one;
      st_wake_stage_two:        next_cfg = cfg_wake_stage_two;
      st_awake_wait:            next_cfg = cfg_awake;
      st_awake:                 next_cfg = cfg_awake;
      st_sleep_entry_stage_one: next_cfg = cfg_sleep_entry_stage_one;
      st_sleep_entry_stage_two: next_cfg = slp2_word;
    endcase
  end

  // ---------------------------------------------------------------
  // Dwell timer
  // ---------------------------------------------------------------
  // Loaded at the entry edge; later writes do not stretch a stay
  pss_dwell_timer #(
    .CNT_W (CNT_W),
    .LOG_W (5)
  ) u_dwell (
    .clk      (clk),
    .reset_n  (reset_n),
    .load     (state_change),
    .log2_len (next_cfg[DWELL_MSB:DWELL_LSB]),
    .expired  (dwell_done)
  );

  // ---------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      st_reset: begin
        next_state = st_waking_one;
      end
      st_asleep: begin
        if (wake_req) begin
          next_state = st_waking_one;
        end
      end
      st_waking_one: begin
        if (dwell_done) begin
          next_state = st_wake_stage_two;
        end
      end
      st_wake_stage_two: begin
        if (dwell_done && supplies_good) begin
          next_state = st_awake_wait;
        end
      end
      st_awake_wait: begin
        if (supplies_good) begin
          next_state = st_awake;
        end
      end
      st_awake: begin
        if (sleep_req) begin
          next_state = st_sleep_entry_stage_one;
        end
      end
      st_sleep_entry_stage_one: begin
        if (dwell_done) begin
          next_state = st_sleep_entry_stage_two;
        end
      end
      st_sleep_entry_stage_two: begin
        if (dwell_done) begin
          next_state = st_asleep;
        end
      end
    endcase
  end

  assign state_change = (next_state != state);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= st_reset;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Applied settings, captured once per entry
  // ---------------------------------------------------------------
  // Snapshot keeps outputs steady for the whole stay
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      applied_clk_gate <= 1'h0;
      applied_ana_pfm  <= 1'h0;
      applied_core_pfm <= 1'h0;
    end else if (state_change) begin
      applied_clk_gate <= next_cfg[CLK_GATE_BIT];
      applied_ana_pfm  <= next_cfg[ANA_PFM_BIT];
      applied_core_pfm <= next_cfg[CORE_PFM_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      applied_io_en   <= 1'h0;
      applied_pll_en  <= 1'h0;
      applied_ana_en  <= 1'h0;
      applied_core_en <= 1'h0;
    end else if (state_change) begin
      applied_io_en   <= next_cfg[IO_EN_BIT];
      applied_pll_en  <= next_cfg[PLL_EN_BIT];
      applied_ana_en  <= next_cfg[ANA_EN_BIT];
      applied_core_en <= next_cfg[CORE_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Previous-state enables
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_io_en   <= PREV_IO_RST;
      prev_pll_en  <= PREV_PLL_RST;
      prev_ana_en  <= PREV_ANA_RST;
      prev_core_en <= PREV_CORE_RST;
    end else if (state_change) begin
      prev_io_en   <= applied_io_en;
      prev_pll_en  <= applied_pll_en;
      prev_ana_en  <= applied_ana_en;
      prev_core_en <= applied_core_en;
    end
  end

  // ---------------------------------------------------------------
  // Outputs to converters, regulators and clock gate
  // ---------------------------------------------------------------
  assign core_buck_converter_en    = applied_core_en;
  assign analog_buck_converter_en  = applied_ana_en;
  assign pll_linear_regulator_en   = applied_pll_en;
  assign io_supply_output_en       = applied_io_en;
  assign core_buck_converter_pfm   = applied_core_pfm;
  assign analog_buck_converter_pfm = applied_ana_pfm;
  assign tile_clk_gate             = applied_clk_gate;
  assign seq_state                 = state;

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  always_comb begin
    stat_word                      = '0;
    stat_word[PREV_IO_BIT]         = prev_io_en;
    stat_word[PREV_PLL_BIT]        = prev_pll_en;
    stat_word[PREV_ANA_BIT]        = prev_ana_en;
    stat_word[PREV_CORE_BIT]       = prev_core_en;
    stat_word[STATE_MSB:STATE_LSB] = state;
    stat_word[CLK_GATE_BIT]        = applied_clk_gate;
    stat_word[ANA_PFM_BIT]         = applied_ana_pfm;
    stat_word[CORE_PFM_BIT]        = applied_core_pfm;
    stat_word[IO_EN_BIT]           = applied_io_en;
    stat_word[PLL_EN_BIT]          = applied_pll_en;
    stat_word[ANA_EN_BIT]          = applied_ana_en;
    stat_word[CORE_EN_BIT]         = applied_core_en;
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Data stand one cycle only; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == ADDR_W'(SLP2_CFG_OFS)) begin
      reg_rdata <= slp2_word;
    end else if (reg_rd && reg_addr == ADDR_W'(SEQ_STAT_OFS)) begin
      reg_rdata <= stat_word;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

/* File: test/pss_supply_model.sv */
// Behavioural model of the supplies that answer the sequencer enables
`timescale 1ns/1ns
module pss_supply_model #(
  parameter int DLY = 3
) (
  // Clock
  input  wire logic clk,
  // Enables from the sequencer
  input  wire logic core_en,
  input  wire logic pll_en,
  // Supply good pins
  output logic      core_good_pin,
  output logic      pll_good_pin
);
  logic [DLY-1:0] core_ramp = '0;
  logic [DLY-1:0] pll_ramp  = '0;

  // Good only after the enable has held DLY cycles, so the sequencer must wait
  always @(posedge clk) begin
    core_ramp <= {core_ramp[DLY-2:0], core_en};
    pll_ramp  <= {pll_ramp[DLY-2:0], pll_en};
  end

  assign core_good_pin = &core_ramp;
  assign pll_good_pin  = &pll_ramp;
endmodule

/* File: test/pss_sequencer_assertions.sv */
// Port checker for the sleep stage two sequencer
`timescale 1ns/1ns
module pss_sequencer_checker
  import pss_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 32
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  // Supply and clock controls
  input wire logic              core_buck_converter_en,
  input wire logic              analog_buck_converter_en,
  input wire logic              pll_linear_regulator_en,
  input wire logic              io_supply_output_en,
  input wire logic              core_buck_converter_pfm,
  input wire logic              analog_buck_converter_pfm,
  input wire logic              tile_clk_gate,
  input wire logic [2:0]        seq_state,
  // Supply good pins
  input wire logic              core_good_pin,
  input wire logic              pll_good_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ----
  // Shadow state
  // ----
  logic [31:0] cfg_q, ent_q, stay_q, stat_exp;
  logic [2:0]  last_st;
  logic [3:0]  last_en, prev_q, prev_now;
  logic [6:0]  outs;
  logic        rd_cfg, rd_stat;

  assign outs = {tile_clk_gate, analog_buck_converter_pfm, core_buck_converter_pfm, io_supply_output_en,
                 pll_linear_regulator_en, analog_buck_converter_en, core_buck_converter_en};
  assign rd_cfg   = reg_rd && reg_addr == ADDR_W'(SLP2_CFG_OFS);
  assign rd_stat  = reg_rd && reg_addr == ADDR_W'(SEQ_STAT_OFS);
  // Status prev bits move on the entry edge, one cycle before the shadow sees it
  assign prev_now = (seq_state != last_st) ? last_en : prev_q;
  assign stat_exp = {2'h0, prev_now[3:2], 2'h0, prev_now[1:0], 5'h0, seq_state, 1'h0, outs[6], 4'h0,
                     outs[5:4], 2'h0, outs[3:2], 2'h0, outs[1:0]};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_q <= 32'h0010_0002;
    end else if (reg_wr && reg_addr == ADDR_W'(SLP2_CFG_OFS)) begin
      cfg_q <= (reg_wdata & 32'h001F_4331) | 32'h0000_0002;
    end
  end

  // Frozen while in stage two, so later writes must not leak into the stay
  always_ff @(posedge clk) begin
    if (seq_state != 3'h7) begin
      ent_q <= cfg_q;
    end
  end

  always_ff @(posedge clk) begin
    last_st <= seq_state;
    last_en <= outs[3:0];
    stay_q  <= (seq_state != last_st) ? 32'h1 : stay_q + 32'h1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_q <= 4'h2;
    end else begin
      prev_q <= prev_now;
    end
  end

  // ----
  // Assertions
  // ----
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  state_order_a: assert property (seq_state != $past(seq_state) |-> seq_state == (($past(seq_state) == 3'h0) ?
    3'h2 : ($past(seq_state) == 3'h7) ? 3'h1 : $past(seq_state) + 3'h1)) else $error("illegal state step");
  stage_outs_a: assert property (seq_state == 3'h7 |-> {outs[6:2], outs[0]} ==
    {ent_q[14], ent_q[9:8], ent_q[5:4], ent_q[0]}) else $error("stage two outputs wrong");
  analog_on_a: assert property (seq_state == 3'h7 |-> analog_buck_converter_en)
    else $error("analog converter off in stage two");
  dwell_exact_a: assert property ((seq_state == 3'h1 && $past(seq_state) == 3'h7) |->
    stay_q == (32'h1 << ent_q[20:16])) else $error("stage two stay length wrong");
  stat_state_a: assert property ($past(rd_stat) |-> reg_rdata[18:16] == $past(seq_state))
    else $error("status state field wrong");
  stat_word_a: assert property ($past(rd_stat) |-> reg_rdata == $past(stat_exp))
    else $error("status word wrong");
  cfg_read_a: assert property ($past(rd_cfg) |-> reg_rdata == $past(cfg_q))
    else $error("config read wrong");
  // Goods pass two sync flops, so the pin seen three edges back decided the exit
  wake_good_a: assert property ((seq_state == 3'h4 && $past(seq_state) == 3'h3) |->
    ($past(core_good_pin, 3) || !$past(core_buck_converter_en)) &&
    ($past(pll_good_pin, 3) || !$past(pll_linear_regulator_en))) else $error("wake stage two left early");
endmodule

bind pss_sequencer pss_sequencer_checker #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) chk_u (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_buck_converter_en(core_buck_converter_en),
  .analog_buck_converter_en(analog_buck_converter_en), .pll_linear_regulator_en(pll_linear_regulator_en),
  .io_supply_output_en(io_supply_output_en), .core_buck_converter_pfm(core_buck_converter_pfm),
  .analog_buck_converter_pfm(analog_buck_converter_pfm), .tile_clk_gate(tile_clk_gate),
  .seq_state(seq_state), .core_good_pin(core_good_pin), .pll_good_pin(pll_good_pin));

/* File: test/testbench.sv */
// Self-checking testbench for the sleep stage two sequencer
`timescale 1ns/1ns
module testbench
  import pss_pkg::*;
;
  logic        clk       = 1'b0;
  logic        reset_n   = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        sleep_req = 1'b0;
  logic        wake_req  = 1'b0;
  logic [31:0] cfg [5];
  logic [31:0] reg_rdata, got, cur, nxt;
  logic [6:0]  outs;
  logic        core_en, ana_en, pll_en, io_en, core_pfm, ana_pfm, clk_gate, core_good, pll_good;
  logic [2:0]  seq_state;
  int          bad_count = 0;
  int          n_checks  = 0;
  int          n;

  assign outs = {clk_gate, ana_pfm, core_pfm, io_en, pll_en, ana_en, core_en};

  initial begin
    forever #4 clk = ~clk;
  end

  pss_sequencer #(.ADDR_W(8), .CNT_W(32)) dut_u (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_asleep(cfg[0]), .cfg_waking_one(cfg[1]),
    .cfg_wake_stage_two(cfg[2]), .cfg_awake(cfg[3]), .cfg_sleep_entry_stage_one(cfg[4]),
    .sleep_req(sleep_req), .wake_req(wake_req), .core_good_pin(core_good), .pll_good_pin(pll_good),
    .core_buck_converter_en(core_en), .analog_buck_converter_en(ana_en), .pll_linear_regulator_en(pll_en),
    .io_supply_output_en(io_en), .core_buck_converter_pfm(core_pfm), .analog_buck_converter_pfm(ana_pfm),
    .tile_clk_gate(clk_gate), .seq_state(seq_state));

  pss_supply_model #(.DLY(3)) sup_u (
    .clk(clk), .core_en(core_en), .pll_en(pll_en), .core_good_pin(core_good), .pll_good_pin(pll_good));

  // ----
  // Expectations and bus tasks
  // ----
  // Dwell kept at 0..3 so every stay is short
  function automatic logic [31:0] rnd_cfg();
    rnd_cfg = ($urandom & 32'hFFE0_FFFF) | (32'($urandom_range(3)) << 16);
  endfunction

  function automatic logic [31:0] stat_of(input logic [31:0] w, input logic [31:0] p, input logic [2:0] s);
    stat_of = {2'h0, p[5:4], 2'h0, p[1:0], 5'h0, s, 1'h0, w[14], 4'h0, w[9:8], 2'h0, w[5:4], 2'h0, w[1:0]};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_st(input logic [2:0] s);
    int i;
    i = 0;
    #1;
    while (seq_state !== s && i < 500) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk(32'(seq_state), 32'(s));
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----
  // Tests
  // ----
  initial begin
    void'($urandom(32'h03F5));
    foreach (cfg[i]) cfg[i] = rnd_cfg();
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    reg_rd <= 1'b1;
    reg_addr <= SEQ_STAT_OFS;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, stat_of(32'h0, 32'h2, 3'h0));
    rd(SLP2_CFG_OFS, got);
    chk(got, 32'h0010_0002);
    wr(SLP2_CFG_OFS, 32'hFFFF_FFFF);
    rd(SLP2_CFG_OFS, got);
    chk(got, 32'h001F_4333);
    wr(SEQ_STAT_OFS, 32'hFFFF_FFFF);
    wr(8'h28, 32'h0);
    rd(SLP2_CFG_OFS, got);
    chk(got, 32'h001F_4333);
    rd(8'h28, got);
    chk(got, 32'h0);
    // First stay sets every bit with the shortest dwell
    cur = 32'hFFE0_FFFF;
    wr(SLP2_CFG_OFS, cur);
    for (int k = 0; k < 8; k++) begin
      wait_st(st_awake);
      rd(SEQ_STAT_OFS, got);
      chk(got, stat_of(cfg[3], cfg[3], 3'h5));
      nxt = (k == 5) ? 32'h0003_0000 : rnd_cfg();
      @(posedge clk);
      cfg[0] <= rnd_cfg();
      sleep_req <= 1'b1;
      wait_st(st_sleep_entry_stage_two);
      chk({25'h0, outs}, {25'h0, cur[14], cur[9:8], cur[5:4], 1'b1, cur[0]});
      n = 1;
      // A write and a status read follow the entry; both land inside the stay only for dwells of 2 or 3, and must not disturb it
      fork
        while (seq_state === st_sleep_entry_stage_two && n < 100) begin
          @(posedge clk);
          #1;
          if (seq_state === st_sleep_entry_stage_two) n++;
        end
        begin
          wr(SLP2_CFG_OFS, nxt);
          rd(SEQ_STAT_OFS, got);
        end
      join
      chk(32'(n), 32'h1 << cur[20:16]);
      wait_st(st_asleep);
      rd(SEQ_STAT_OFS, got);
      chk(got, stat_of(cfg[0], cur | 32'h2, 3'h1));
      cur = nxt;
      @(posedge clk);
      for (int j = 1; j < 5; j++) cfg[j] <= rnd_cfg();
      sleep_req <= 1'b0;
      wake_req <= 1'b1;
      wait_st(st_waking_one);
      @(posedge clk);
      wake_req <= 1'b0;
    end
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule
